// *** include/mq_loader_pkg.sv ***
// shared constants, carrier structs and state types of the reset and setup loader
package mq_loader_pkg;

	// ------------------------------------------------------------
	// queue and stream geometry
	// ------------------------------------------------------------
	localparam int QUEUES = 16;
	localparam int QIDX_W = 4;
	localparam int QCNT_W = 5;
	localparam int FIELD_W = 24;
	localparam int HDR_BITS = 19;
	localparam int HDR_QCNT_BITS = 5;
	localparam int QUEUE_BITS = 72;
	localparam int BIT_CNT_W = 7;
	localparam int PRS_CNT_W = 8;
	localparam logic [QCNT_W-1:0] QCOUNT_MAX = 5'h10;
	localparam logic [QCNT_W-1:0] HDR_LAST = 5'h12;
	localparam logic [QCNT_W-1:0] HDR_QCNT_END = 5'h05;
	localparam logic [BIT_CNT_W-1:0] QUEUE_LAST_BIT = 7'h47;
	localparam logic [QUEUES-1:0] ONE_HOT_BASE = 16'h0001;

	// ------------------------------------------------------------
	// default setup values
	// ------------------------------------------------------------
	localparam logic [FIELD_W-1:0] DEFAULT_DEPTH_X9 = 24'h001000;
	localparam logic [FIELD_W-1:0] DEFAULT_DEPTH_X18 = DEFAULT_DEPTH_X9 >> 1;
	localparam logic [FIELD_W-1:0] DEFAULT_OFFSET_LOW = 24'h000008;
	localparam logic [FIELD_W-1:0] DEFAULT_OFFSET_HIGH = 24'h000080;

	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_STRAPS = 8'h08;
	localparam logic [7:0] OFF_SETUP_SEL = 8'h0C;
	localparam logic [7:0] OFF_SETUP_DEPTH = 8'h10;
	localparam logic [7:0] OFF_SETUP_AE = 8'h14;
	localparam logic [7:0] OFF_SETUP_AF = 8'h18;
	localparam int CTRL_WSEL_LSB = 0;
	localparam int CTRL_RSEL_LSB = 4;
	localparam int SETUP_SEL_LSB = 0;
	localparam int STATUS_DONE_BIT = 0;
	localparam int STATUS_SERIAL_BIT = 1;
	localparam int STATUS_LOADING_BIT = 2;
	localparam int STATUS_QCNT_LSB = 3;
	localparam int STATUS_PRS_LSB = 8;
	localparam int HTRANS_ACTIVE_BIT = 1;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic default_offset_strap;
		logic programming_method_strap;
		logic device_identity_bit2;
		logic device_identity_bit1;
		logic device_identity_bit0;
		logic master_device_strap;
		logic output_width_strap;
		logic input_width_strap;
		logic flag_bus_mode_strap;
	} straps_t;

	typedef struct packed {
		logic write_clock;
		logic serial_clock;
		logic serial_data;
		logic serial_in_enable_n;
		logic queue_pointer_reset_n;
		logic master_reset_n;
		straps_t straps;
	} pins_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_t;

	typedef struct packed {
		logic [FIELD_W-1:0] depth;
		logic [FIELD_W-1:0] ae_offset;
		logic [FIELD_W-1:0] af_offset;
	} queue_setup_t;

	typedef struct packed {
		queue_setup_t [QUEUES-1:0] entry;
	} store_state_t;

	typedef enum logic [2:0] {
		ST_MR_HOLD,
		ST_SER_HDR,
		ST_SER_BODY,
		ST_DEF_LOAD,
		ST_DONE
	} load_state_t;

	typedef struct packed {
		load_state_t state;
		straps_t straps;
		logic mr_prev;
		logic prs_prev;
		logic sclk_prev;
		logic wclk_prev;
		logic [QCNT_W-1:0] qcount;
		logic [QCNT_W-1:0] hdr_cnt;
		logic [BIT_CNT_W-1:0] bit_cnt;
		logic [QCNT_W-1:0] q_idx;
		logic [QUEUE_BITS-1:0] shifter;
		logic serial_out_enable_n;
		logic so;
		logic cfg_ready;
		logic [QUEUES-1:0] wr_clr;
		logic [QUEUES-1:0] rd_clr;
		logic [PRS_CNT_W-1:0] prs_count;
		logic [QIDX_W-1:0] wr_sel;
		logic [QIDX_W-1:0] rd_sel;
		logic [QIDX_W-1:0] setup_sel;
		logic dp_write;
		logic dp_read;
		logic dp_mapped;
		logic [7:0] dp_addr;
		ahb_rsp_t rsp;
	} loader_state_t;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam pins_t PINS_RESET = '{master_reset_n: 1'b1, queue_pointer_reset_n: 1'b1,
		serial_in_enable_n: 1'b1, default: '0};
	localparam store_state_t STORE_RESET = '0;
	localparam loader_state_t LOADER_RESET = '{state: ST_MR_HOLD, mr_prev: 1'b1,
		prs_prev: 1'b1, serial_out_enable_n: 1'b1, rsp: '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0},
		default: '0};

endpackage

// *** tb/mq_program_host.sv ***
// programming controller model: serial port and write clock source
`timescale 1ns/1ps
`default_nettype none

module mq_program_host (
	input wire logic serial_out_enable_n_n_i,
	output logic sclk_o,
	output logic sdata_o,
	output logic serial_in_enable_n_n_o,
	output logic wclk_o
);
	initial begin
		{sclk_o, sdata_o, serial_in_enable_n_n_o, wclk_o} = 4'h2;
	end
	task automatic shift(input logic b);
		if (serial_out_enable_n_n_i !== 1'h0) begin
			sdata_o = b;
			#24 sclk_o = 1'h1;
			#24 sclk_o = 1'h0;
		end
	endtask
	// framing; a released data line flips so no stale value survives
	task automatic frame(input logic on);
		serial_in_enable_n_n_o = !on;
		if (!on) sdata_o = !sdata_o;
	endtask
	// write clock bursts, still between bursts
	task automatic wclocks(input int n);
		repeat (n) begin
			#24 wclk_o = 1'h1;
			#24 wclk_o = 1'h0;
		end
	endtask
endmodule // mq_program_host
`default_nettype wire

// *** tb/multiqueue_reset_config_loader_monitor.sv ***
// port checker for the reset and setup loader
`timescale 1ns/1ps
`default_nettype none

module multiqueue_reset_config_loader_monitor (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire mq_loader_pkg::ahb_req_t ahb_i,
	input wire mq_loader_pkg::ahb_rsp_t ahb_o,
	input wire logic master_reset_n_i,
	input wire logic queue_pointer_reset_n_i,
	input wire logic serial_data_i,
	input wire logic serial_in_enable_n_i,
	input wire logic serial_out_enable_n_o,
	input wire logic serial_data_o,
	input wire logic config_ready_o,
	input wire logic [mq_loader_pkg::QUEUES-1:0] write_pointer_clear_o,
	input wire logic [mq_loader_pkg::QUEUES-1:0] read_pointer_clear_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// --------
	// sequences
	// --------
	sequence s_mr_high;
		master_reset_n_i [*4];
	endsequence
	sequence s_rd_taken;
		ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && !ahb_i.hwrite;
	endsequence
	// --------
	// properties
	// --------
	a_mr_clears_done: assert property ($fell(master_reset_n_i) |->
		##[1:4] (!config_ready_o && serial_out_enable_n_o)) else $error("master reset not seen");
	a_mr_holds_idle: assert property (!master_reset_n_i [*7] |-> !config_ready_o)
		else $error("done while in master reset");
	a_ready_holds: assert property (s_mr_high ##0 config_ready_o |=> config_ready_o)
		else $error("setup done dropped");
	a_serial_out_enable_n_follows: assert property (config_ready_o && $rose(serial_in_enable_n_i) |->
		##[1:5] serial_out_enable_n_o) else $error("enable out did not follow");
	a_done_pairs: assert property ($fell(serial_out_enable_n_o) |-> ##[0:1] config_ready_o)
		else $error("enable out low before done");
	a_so_passes: assert property ((config_ready_o && master_reset_n_i && $stable(serial_data_i))
		[*5] |-> serial_data_o == serial_data_i) else $error("serial data not passed");
	a_clear_onehot: assert property (|write_pointer_clear_o |->
		$onehot(write_pointer_clear_o) && $onehot(read_pointer_clear_o) ##1 !(|write_pointer_clear_o))
		else $error("pointer clear not a one-hot pulse");
	a_clear_cause: assert property (|write_pointer_clear_o |->
		config_ready_o && !$past(queue_pointer_reset_n_i, 2)) else $error("clear without cause");
	a_read_wait: assert property (s_rd_taken |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (ahb_o.hresp == 1'h0) else $error("error response");
endmodule // multiqueue_reset_config_loader_monitor

bind multiqueue_reset_config_loader multiqueue_reset_config_loader_monitor
	i_multiqueue_reset_config_loader_monitor (.clk_sys_i, .reset_n_i, .ahb_i, .ahb_o,
	.master_reset_n_i, .queue_pointer_reset_n_i, .serial_data_i, .serial_in_enable_n_i,
	.serial_out_enable_n_o, .serial_data_o, .config_ready_o, .write_pointer_clear_o,
	.read_pointer_clear_o);
`default_nettype wire

// *** tb/multiqueue_reset_config_loader_test.sv ***
// bench: master reset, serial and default loading, partial reset
`timescale 1ns/1ps
`default_nettype none

module multiqueue_reset_config_loader_test;
	logic clk_sys_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic clk_en = 1'h1;
	logic mr_n = 1'h1;
	logic prs_n = 1'h1;
	mq_loader_pkg::straps_t straps = '0;
	mq_loader_pkg::ahb_req_t req = '0;
	mq_loader_pkg::ahb_req_t req_in;
	mq_loader_pkg::ahb_rsp_t rsp;
	logic sclk, sdata, serial_in_enable_n_n, wclk, serial_out_enable_n_n, so, ready;
	logic [15:0] wclr, rclr;
	logic [15:0] wseen = '0;
	logic [15:0] rseen = '0;
	logic [31:0] rd;
	logic [90:0] stream;
	int errors = 0;
	int n_checks = 0;

	initial begin
		forever #2.5 clk_sys_i = !clk_sys_i;
	end
	always_comb begin
		req_in = req;
		req_in.hready = rsp.hreadyout;
	end
	always @(posedge clk_sys_i) begin
		if (|wclr) begin
			{wseen, rseen} <= {wclr, rclr};
		end
	end

	multiqueue_reset_config_loader i_multiqueue_reset_config_loader (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .clk_en_i(clk_en), .ahb_i(req_in), .ahb_o(rsp),
		.master_reset_n_i(mr_n), .queue_pointer_reset_n_i(prs_n), .straps_i(straps),
		.serial_clock_i(sclk), .serial_data_i(sdata), .serial_in_enable_n_i(serial_in_enable_n_n),
		.write_clock_i(wclk), .serial_out_enable_n_o(serial_out_enable_n_n), .serial_data_o(so),
		.config_ready_o(ready), .write_pointer_clear_o(wclr), .read_pointer_clear_o(rclr));
	mq_program_host i_mq_program_host (.serial_out_enable_n_n_i(serial_out_enable_n_n), .sclk_o(sclk), .sdata_o(sdata),
		.serial_in_enable_n_n_o(serial_in_enable_n_n), .wclk_o(wclk));

	// --------
	// tasks
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic pause;
		repeat (12) @(posedge clk_sys_i);
	endtask
	task automatic step_ready;
		@(posedge clk_sys_i);
		while (rsp.hreadyout !== 1'h1) @(posedge clk_sys_i);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req <= '{hsel: 1'h1, haddr: {24'h0, a}, htrans: 2'h2, hwrite: w, hsize: 3'h2, default: '0};
		step_ready();
		req <= '{hwdata: d, default: '0};
		step_ready();
		rd = rsp.hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	// p low: master reset pulse, p high: partial reset pulse
	task automatic pulse(input logic p);
		@(posedge clk_sys_i);
		{mr_n, prs_n} <= {p, !p};
		repeat (8) @(posedge clk_sys_i);
		{mr_n, prs_n} <= 2'h3;
		pause();
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// --------
	// sequence
	// --------
	initial begin
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'h1;
		rchk(8'h1C, 32'h0);
		straps <= 9'h05D;
		pulse(1'h0);
		straps <= 9'h1FF;
		rchk(8'h08, 32'h5D);
		// header of one queue, then af, ae and depth fields
		stream = {24'h000333, 24'h000022, 24'h000011, 14'h0, 5'h01};
		i_mq_program_host.frame(1'h1);
		for (int i = 0; i < 90; i++) i_mq_program_host.shift(stream[i]);
		pause();
		chb(serial_out_enable_n_n, 1'h1);
		chb(ready, 1'h0);
		i_mq_program_host.shift(stream[90]);
		pause();
		chb(serial_out_enable_n_n, 1'h0);
		chb(ready, 1'h1);
		i_mq_program_host.frame(1'h0);
		pause();
		chb(serial_out_enable_n_n, 1'h1);
		chb(so, sdata);
		bus(1'h1, 8'h0C, 32'h0);
		rchk(8'h10, 32'h333);
		rchk(8'h14, 32'h22);
		rchk(8'h18, 32'h11);
		rchk(8'h04, 32'h0B);
		// write side queue 3, read side queue 5
		bus(1'h1, 8'h00, 32'h53);
		pulse(1'h1);
		chk({wseen, rseen}, 32'h0008_0020);
		rchk(8'h04, 32'h10B);
		rchk(8'h10, 32'h333);
		// a frozen block must not see this partial reset
		clk_en <= 1'h0;
		pulse(1'h1);
		clk_en <= 1'h1;
		rchk(8'h04, 32'h10B);
		for (int k = 0; k < 2; k++) begin
			straps <= k ? 9'h182 : 9'h080;
			pulse(1'h0);
			rchk(8'h00, 32'h0);
			bus(1'h1, 8'h0C, 32'hF);
			rchk(8'h10, 32'h0);
			i_mq_program_host.frame(1'h1);
			for (int i = 0; i < 19; i++) i_mq_program_host.shift(1'h0);
			i_mq_program_host.wclocks(15);
			pause();
			chb(serial_out_enable_n_n, 1'h1);
			i_mq_program_host.wclocks(1);
			pause();
			chb(serial_out_enable_n_n, 1'h0);
			rchk(8'h10, 32'(mq_loader_pkg::DEFAULT_DEPTH_X9 >> k));
			rchk(8'h14, k ? 32'h80 : 32'h8);
			rchk(8'h18, k ? 32'h80 : 32'h8);
			bus(1'h0, 8'h04, 32'h0);
			chk(rd & 32'hFF, 32'h81);
			i_mq_program_host.frame(1'h0);
		end
		end_of_test();
	end
	// the whole run needs about 9 us
	initial begin
		#200us;
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule // multiqueue_reset_config_loader_test
`default_nettype wire

// *** verilog/multiqueue_reset_config_loader.sv ***
// master reset, partial reset and setup loading of a multi-queue device
//
// Behaviour
// (R1) master reset pulse reinitialises all setup registers
// (R2) straps define function during master reset
// (R3) no queue traffic before programming completes
// (R4) queue selected both ports before partial reset
// (R5) partial reset low one clock each port
// (R6) three clocks each port after partial reset
// (R7) partial reset clears only selected queue pointers
// (R8) method strap low requires serial setup loading
// (R9) serial load is 19 plus 72 per queue
// (R10) sample serial data on clock rise, enable low
// (R11) serial output enable low, then follows input
// (R12) after completion serial data passes straight through
// (R13) controller stops shifting, raises enable on completion
// (R14) cascade chains enable and data, shared clock
// (R15) last device enable low means chain done
// (R16) queue selections only after all programming done
// (R17) method strap high: default setup, serial refused
// (R18) default: sixteen queues, x9 depth doubles x18
// (R19) default offsets 8 or 128 by strap
// (R20) default load clocked by write clock edges
// (R21) serial input enable held low during default
// (R22) default cascade chains enables, last signals done
// (R23) straps captured at release, held until next
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module multiqueue_reset_config_loader (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire mq_loader_pkg::ahb_req_t ahb_i,
	output mq_loader_pkg::ahb_rsp_t ahb_o,
	input wire logic master_reset_n_i,
	input wire logic queue_pointer_reset_n_i,
	input wire mq_loader_pkg::straps_t straps_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	input wire logic serial_in_enable_n_i,
	input wire logic write_clock_i,
	output logic serial_out_enable_n_o,
	output logic serial_data_o,
	output logic config_ready_o,
	output logic [mq_loader_pkg::QUEUES-1:0] write_pointer_clear_o,
	output logic [mq_loader_pkg::QUEUES-1:0] read_pointer_clear_o
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	mq_loader_pkg::pins_t pins_raw;
	mq_loader_pkg::pins_t pins_s;

	assign pins_raw = '{
		write_clock: write_clock_i,
		serial_clock: serial_clock_i,
		serial_data: serial_data_i,
		serial_in_enable_n: serial_in_enable_n_i,
		queue_pointer_reset_n: queue_pointer_reset_n_i,
		master_reset_n: master_reset_n_i,
		straps: straps_i
	};

	// data and enable share the clock's delay, so they stay aligned to its edge
	pin_sync #(
		.WIDTH($bits(mq_loader_pkg::pins_t)),
		.RESET_VALUE(mq_loader_pkg::PINS_RESET)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	// ------------------------------------------------------------
	// state and edge detection
	// ------------------------------------------------------------
	mq_loader_pkg::loader_state_t st_reg;
	mq_loader_pkg::loader_state_t st_next;

	logic sclk_rise;
	logic wclk_rise;
	logic mr_rise;
	logic prs_fall;
	logic bus_accept;
	logic [mq_loader_pkg::QCNT_W-1:0] q_idx_inc;

	assign sclk_rise = pins_s.serial_clock & ~st_reg.sclk_prev;
	assign wclk_rise = pins_s.write_clock & ~st_reg.wclk_prev;
	assign mr_rise = pins_s.master_reset_n & ~st_reg.mr_prev;
	assign prs_fall = ~pins_s.queue_pointer_reset_n & st_reg.prs_prev;
	assign q_idx_inc = st_reg.q_idx + 5'h01;
	assign bus_accept = ahb_i.hsel & ahb_i.htrans[mq_loader_pkg::HTRANS_ACTIVE_BIT] & ahb_i.hready;

	// ------------------------------------------------------------
	// setup storage
	// ------------------------------------------------------------
	logic store_clear;
	logic store_we;
	logic [mq_loader_pkg::QIDX_W-1:0] store_widx;
	mq_loader_pkg::queue_setup_t store_wdata;
	mq_loader_pkg::queue_setup_t store_rdata;

	queue_setup_store u_store (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.clear_i(store_clear),
		.write_en_i(store_we),
		.write_index_i(store_widx),
		.write_data_i(store_wdata),
		.read_index_i(st_reg.setup_sel),
		.read_data_o(store_rdata)
	);

	// ------------------------------------------------------------
	// default setup entry
	// ------------------------------------------------------------
	mq_loader_pkg::queue_setup_t default_entry;

	always_comb begin
		// (R18) depth halves with x18 port
		if (st_reg.straps.input_width_strap || st_reg.straps.output_width_strap) begin
			default_entry.depth = mq_loader_pkg::DEFAULT_DEPTH_X18;
		end else begin
			default_entry.depth = mq_loader_pkg::DEFAULT_DEPTH_X9;
		end
		// (R19) offset chosen by strap
		if (st_reg.straps.default_offset_strap) begin
			default_entry.ae_offset = mq_loader_pkg::DEFAULT_OFFSET_HIGH;
			default_entry.af_offset = mq_loader_pkg::DEFAULT_OFFSET_HIGH;
		end else begin
			default_entry.ae_offset = mq_loader_pkg::DEFAULT_OFFSET_LOW;
			default_entry.af_offset = mq_loader_pkg::DEFAULT_OFFSET_LOW;
		end
	end

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	logic [31:0] read_word;

	always_comb begin
		read_word = 32'h0;
		if (st_reg.dp_mapped) begin
			unique case (st_reg.dp_addr)
				mq_loader_pkg::OFF_CTRL: begin
					read_word[mq_loader_pkg::CTRL_WSEL_LSB +: mq_loader_pkg::QIDX_W] = st_reg.wr_sel;
					read_word[mq_loader_pkg::CTRL_RSEL_LSB +: mq_loader_pkg::QIDX_W] = st_reg.rd_sel;
				end
				mq_loader_pkg::OFF_STATUS: begin
					read_word[mq_loader_pkg::STATUS_DONE_BIT] = st_reg.cfg_ready;
					read_word[mq_loader_pkg::STATUS_SERIAL_BIT] =
						~st_reg.straps.programming_method_strap;
					read_word[mq_loader_pkg::STATUS_LOADING_BIT] =
						(st_reg.state == mq_loader_pkg::ST_SER_HDR) ||
						(st_reg.state == mq_loader_pkg::ST_SER_BODY) ||
						(st_reg.state == mq_loader_pkg::ST_DEF_LOAD);
					read_word[mq_loader_pkg::STATUS_QCNT_LSB +: mq_loader_pkg::QCNT_W] = st_reg.qcount;
					read_word[mq_loader_pkg::STATUS_PRS_LSB +: mq_loader_pkg::PRS_CNT_W] =
						st_reg.prs_count;
				end
				mq_loader_pkg::OFF_STRAPS: begin
					read_word[$bits(mq_loader_pkg::straps_t)-1:0] = st_reg.straps;
				end
				mq_loader_pkg::OFF_SETUP_SEL: begin
					read_word[mq_loader_pkg::SETUP_SEL_LSB +: mq_loader_pkg::QIDX_W] = st_reg.setup_sel;
				end
				mq_loader_pkg::OFF_SETUP_DEPTH: begin
					read_word[mq_loader_pkg::FIELD_W-1:0] = store_rdata.depth;
				end
				mq_loader_pkg::OFF_SETUP_AE: begin
					read_word[mq_loader_pkg::FIELD_W-1:0] = store_rdata.ae_offset;
				end
				mq_loader_pkg::OFF_SETUP_AF: begin
					read_word[mq_loader_pkg::FIELD_W-1:0] = store_rdata.af_offset;
				end
				default: begin
					read_word = 32'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		store_clear = 1'b0;
		store_we = 1'b0;
		store_widx = '0;
		store_wdata = '0;
		st_next.mr_prev = pins_s.master_reset_n;
		st_next.prs_prev = pins_s.queue_pointer_reset_n;
		st_next.sclk_prev = pins_s.serial_clock;
		st_next.wclk_prev = pins_s.write_clock;
		st_next.wr_clr = '0;
		st_next.rd_clr = '0;

		if (!pins_s.master_reset_n) begin
			// (R1) master reset clears setup
			st_next.state = mq_loader_pkg::ST_MR_HOLD;
			store_clear = 1'b1;
			st_next.cfg_ready = 1'b0;
			st_next.serial_out_enable_n = 1'b1;
			st_next.so = 1'b0;
			st_next.qcount = '0;
			st_next.hdr_cnt = '0;
			st_next.bit_cnt = '0;
			st_next.q_idx = '0;
			st_next.shifter = '0;
			st_next.wr_sel = '0;
			st_next.rd_sel = '0;
		end else begin
			unique case (st_reg.state)
				mq_loader_pkg::ST_MR_HOLD: begin
					if (mr_rise) begin
						// (R2) (R23) straps caught at release
						st_next.straps = pins_s.straps;
						// (R8) (R17) method strap picks loader
						if (pins_s.straps.programming_method_strap) begin
							st_next.state = mq_loader_pkg::ST_DEF_LOAD;
						end else begin
							st_next.state = mq_loader_pkg::ST_SER_HDR;
						end
					end
				end
				mq_loader_pkg::ST_SER_HDR: begin
					// (R10) shift on clock rise
					if (sclk_rise && !pins_s.serial_in_enable_n) begin
						if (st_reg.hdr_cnt < mq_loader_pkg::HDR_QCNT_END) begin
							st_next.qcount = {pins_s.serial_data, st_reg.qcount[mq_loader_pkg::QCNT_W-1:1]};
						end
						st_next.hdr_cnt = st_reg.hdr_cnt + 5'h01;
						// (R9) header is nineteen bits
						if (st_reg.hdr_cnt == mq_loader_pkg::HDR_LAST) begin
							if (st_reg.qcount > mq_loader_pkg::QCOUNT_MAX) begin
								st_next.qcount = mq_loader_pkg::QCOUNT_MAX;
							end
							if (st_reg.qcount == '0) begin
								st_next.state = mq_loader_pkg::ST_DONE;
								st_next.cfg_ready = 1'b1;
								st_next.serial_out_enable_n = pins_s.serial_in_enable_n;
							end else begin
								st_next.state = mq_loader_pkg::ST_SER_BODY;
							end
						end
					end
				end
				mq_loader_pkg::ST_SER_BODY: begin
					// (R10) shift on clock rise
					if (sclk_rise && !pins_s.serial_in_enable_n) begin
						st_next.shifter = {pins_s.serial_data,
							st_reg.shifter[mq_loader_pkg::QUEUE_BITS-1:1]};
						st_next.bit_cnt = st_reg.bit_cnt + 7'h01;
						// (R9) seventy-two bits per queue
						if (st_reg.bit_cnt == mq_loader_pkg::QUEUE_LAST_BIT) begin
							store_we = 1'b1;
							store_widx = st_reg.q_idx[mq_loader_pkg::QIDX_W-1:0];
							store_wdata = st_next.shifter;
							st_next.bit_cnt = '0;
							st_next.q_idx = q_idx_inc;
							if (q_idx_inc == st_reg.qcount) begin
								st_next.state = mq_loader_pkg::ST_DONE;
								st_next.cfg_ready = 1'b1;
								// (R11) enable output goes low
								st_next.serial_out_enable_n = pins_s.serial_in_enable_n;
							end
						end
					end
				end
				mq_loader_pkg::ST_DEF_LOAD: begin
					// (R20) one queue per write clock
					if (wclk_rise) begin
						store_we = 1'b1;
						store_widx = st_reg.q_idx[mq_loader_pkg::QIDX_W-1:0];
						store_wdata = default_entry;
						st_next.q_idx = q_idx_inc;
						// (R18) all sixteen queues set up
						if (q_idx_inc == mq_loader_pkg::QCOUNT_MAX) begin
							st_next.qcount = mq_loader_pkg::QCOUNT_MAX;
							st_next.state = mq_loader_pkg::ST_DONE;
							st_next.cfg_ready = 1'b1;
							// (R20) (R22) completion on enable output
							st_next.serial_out_enable_n = pins_s.serial_in_enable_n;
						end
					end
				end
				mq_loader_pkg::ST_DONE: begin
					// (R11) enable output follows input
					st_next.serial_out_enable_n = pins_s.serial_in_enable_n;
					// (R12) serial data bypass
					st_next.so = pins_s.serial_data;
					// (R7) clear only selected pointers
					if (prs_fall) begin
						st_next.wr_clr = mq_loader_pkg::ONE_HOT_BASE << st_reg.wr_sel;
						st_next.rd_clr = mq_loader_pkg::ONE_HOT_BASE << st_reg.rd_sel;
						st_next.prs_count = st_reg.prs_count + 8'h01;
					end
				end
			endcase
		end

		// bus data phase: writes land here, reads were stalled one cycle
		if (st_reg.dp_write && st_reg.dp_mapped) begin
			unique case (st_reg.dp_addr)
				mq_loader_pkg::OFF_CTRL: begin
					st_next.wr_sel = ahb_i.hwdata[mq_loader_pkg::CTRL_WSEL_LSB +: mq_loader_pkg::QIDX_W];
					st_next.rd_sel = ahb_i.hwdata[mq_loader_pkg::CTRL_RSEL_LSB +: mq_loader_pkg::QIDX_W];
				end
				mq_loader_pkg::OFF_SETUP_SEL: begin
					st_next.setup_sel =
						ahb_i.hwdata[mq_loader_pkg::SETUP_SEL_LSB +: mq_loader_pkg::QIDX_W];
				end
				default: begin
					st_next.setup_sel = st_reg.setup_sel;
				end
			endcase
		end
		if (st_reg.dp_read) begin
			st_next.rsp.hrdata = read_word;
			st_next.rsp.hreadyout = 1'b1;
		end

		// bus address phase
		st_next.dp_write = bus_accept & ahb_i.hwrite;
		st_next.dp_read = bus_accept & ~ahb_i.hwrite;
		if (bus_accept) begin
			st_next.dp_addr = ahb_i.haddr[7:0];
			st_next.dp_mapped = (ahb_i.haddr[31:8] == 24'h000000) && (ahb_i.haddr[1:0] == 2'h0);
			if (!ahb_i.hwrite) begin
				st_next.rsp.hreadyout = 1'b0;
			end
		end
		st_next.rsp.hresp = 1'b0;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= mq_loader_pkg::LOADER_RESET;
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign ahb_o = st_reg.rsp;
	assign serial_out_enable_n_o = st_reg.serial_out_enable_n;
	assign serial_data_o = st_reg.so;
	// (R3) traffic gate for the queue ports
	assign config_ready_o = st_reg.cfg_ready;
	assign write_pointer_clear_o = st_reg.wr_clr;
	assign read_pointer_clear_o = st_reg.rd_clr;

endmodule // multiqueue_reset_config_loader

`default_nettype wire

// *** verilog/pin_sync.sv ***
// two-flop synchroniser for pins arriving from outside the system clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// the first stage feeds only the second stage
	always_comb begin
		st_next = st_reg;
		st_next.meta = d_i;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= '{meta: RESET_VALUE, stable: RESET_VALUE};
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.stable;

endmodule // pin_sync

`default_nettype wire

// *** verilog/queue_setup_store.sv ***
// per-queue setup storage: depth and almost-empty / almost-full offsets
`timescale 1ns/1ps
`default_nettype none

module queue_setup_store (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic clear_i,
	input wire logic write_en_i,
	input wire logic [mq_loader_pkg::QIDX_W-1:0] write_index_i,
	input wire mq_loader_pkg::queue_setup_t write_data_i,
	input wire logic [mq_loader_pkg::QIDX_W-1:0] read_index_i,
	output mq_loader_pkg::queue_setup_t read_data_o
);

	mq_loader_pkg::store_state_t st_reg;
	mq_loader_pkg::store_state_t st_next;

	// clear wins: a master reset must leave no stale setup behind
	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < mq_loader_pkg::QUEUES; i++) begin
			if (clear_i) begin
				st_next.entry[i] = '0;
			end else if (write_en_i && (write_index_i == i[mq_loader_pkg::QIDX_W-1:0])) begin
				st_next.entry[i] = write_data_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= mq_loader_pkg::STORE_RESET;
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	assign read_data_o = st_reg.entry[read_index_i];

endmodule // queue_setup_store

`default_nettype wire
